// file: logic/bizt_pkg.sv
// Package for the bus interface zone timing block: offsets, fields, resets, types
package bizt_pkg;

  // Register byte addresses on the configuration port (24-bit space)
  localparam logic [23:0] ADDR_WRITE_TIMING = 24'hFFF900;
  localparam logic [23:0] ADDR_IO_ZONE      = 24'hFFF902;
  localparam logic [23:0] ADDR_ZONE0        = 24'hFFF904;
  localparam logic [23:0] ADDR_ZONE1        = 24'hFFF906;
  localparam logic [23:0] ADDR_ZONE2        = 24'hFFF908;

  // Values after reset
  localparam logic [7:0]  RST_WRITE_TIMING  = 8'h07;
  localparam logic [15:0] RST_ZONE_CFG      = 16'h069F;
  localparam logic [15:0] RST_ZONE12_CFG    = 16'h069F;

  // Cycles counted after reset release before the boot pins are trusted
  localparam logic [1:0]  ENV_SETTLE_CNT    = 2'h3;

  // Write-timing register bits that always read as written ones
  localparam logic [7:0]  WT_FIXED_ONES     = 8'h06;

  // Zone configuration and write-timing field positions
  localparam int WAIT_LSB  = 0;
  localparam int HOLD_LSB  = 3;
  localparam int RBE_BIT   = 5;
  localparam int WBR_BIT   = 6;
  localparam int BW_BIT    = 7;
  localparam int IDLE_AFTER_ZONE_CHANGE_BIT  = 9;
  localparam int IDLE_BEFORE_ZONE_CHANGE_BIT  = 10;
  localparam int FRE_BIT   = 11;
  localparam int EWR_BIT   = 0;

  // Writable bit masks for the I/O zone and zone 0 registers
  localparam logic [15:0] IO_ZONE_MASK = 16'h029F;
  localparam logic [15:0] ZONE0_MASK   = 16'h0EFF;

  // I/O zone window
  localparam logic [23:0] IO_ZONE_BASE = 24'hFFFB00;
  localparam logic [23:0] IO_ZONE_LAST = 24'hFFFBFF;
  // Static zone 0 upper bound (flash program and data memory)
  localparam logic [23:0] ZONE0_LAST   = 24'h0DFFFF;

  // Boot-select codes
  localparam logic [2:0] BOOT_INTERNAL = 3'h7;
  localparam logic [2:0] BOOT_EXTERNAL = 3'h3;
  localparam logic [2:0] BOOT_EMU_EXT  = 3'h0;
  localparam logic [2:0] BOOT_EMU_INT  = 3'h1;
  localparam logic [2:0] BOOT_ISP      = 3'h6;

  // Operating environments
  typedef enum logic [2:0] {
    ENV_INTERNAL = 3'b000,
    ENV_EXTERNAL = 3'b001,
    ENV_EMU_EXT  = 3'b010,
    ENV_EMU_INT  = 3'b011,
    ENV_ISP      = 3'b100
  } bizt_env_t;

  // Zones
  typedef enum logic [1:0] {
    ZONE_NONE = 2'b00,
    ZONE_0    = 2'b01,
    ZONE_IO   = 2'b10
  } bizt_zone_t;

  // Bus-cycle phases
  typedef enum logic [2:0] {
    PH_IDLE  = 3'b000,
    PH_PRE   = 3'b001,
    PH_ADDR  = 3'b010,
    PH_WAIT  = 3'b011,
    PH_DATA  = 3'b100,
    PH_BURST = 3'b101,
    PH_HOLD  = 3'b110,
    PH_POST  = 3'b111
  } bizt_phase_t;

  // Core-bus request
  typedef struct packed {
    logic [23:0] addr;
    logic        write;
    logic        word;
    logic [15:0] wdata;
  } bizt_req_t;

  // Timing plan resolved for one access
  typedef struct packed {
    bizt_zone_t zone;
    logic [2:0] waits;
    logic [1:0] holds;
    logic       fast;
    logic       burst;
    logic       burst_wait;
    logic       early;
    logic       post_idle;
  } bizt_plan_t;

endpackage : bizt_pkg

// file: logic/bizt_top.sv
// Bus interface zone timing: cycle sequencer, zone registers, environment decode
//
// Behaviour
// - 111 internal, 011 external when flash programmed
// - 000 external emulation, 001 internal emulation
// - 110, or blank flash on 111/011, selects IN_SYSTEM_PROGRAMMING_MODE
// - Access timing from addressed zone's configuration
// - Normal read two cycles, fast read one
// - Late write two cycles, early write three
// - Reset gives normal reads, early writes
// - Wait cycles follow address phase
// - Hold cycles appended at cycle end
// - Write timing resets 07h, bit0 early
// - Wait field adds zero to seven cycles
// - Hold field gives zero to three cycles
// - Bit 7 selects 8 or 16 bit
// - Post-idle adds idle before zone change
// - Zone0 pre-idle adds idle on zone change
// - Fast read ignores wait, hold, burst
// - Burst for word read on byte zone
// - Burst-wait adds one burst wait state
// - I/O and zone0 registers reset 069Fh
// - I/O zone covers FFFB00h to FFFBFFh
`timescale 1ns/10ps
module bizt_top (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              arst_n,
  // Operating environment inputs
  input  wire logic [2:0]        boot_select_pins,
  input  wire logic              flash_blank,
  // Operating environment outputs
  output bizt_pkg::bizt_env_t    env_mode,
  output logic                   internal_program_mode,
  output logic                   external_program_mode,
  output logic                   emulation_external_mode,
  output logic                   emulation_internal_mode,
  output logic                   in_system_programming_mode,
  // Register port
  input  wire logic [23:0]       reg_addr,
  input  wire logic [15:0]       reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic [15:0]            reg_rdata,
  // Core bus request
  input  wire logic              core_valid,
  input  wire bizt_pkg::bizt_req_t core_req,
  output logic                   core_ready,
  output logic                   core_done,
  output logic [15:0]            core_rdata,
  // Target bus
  output logic                   tgt_select_zone0,
  output logic                   tgt_select_io,
  output logic [23:0]            tgt_addr,
  output logic                   tgt_rd,
  output logic                   tgt_wr,
  output logic [15:0]            tgt_wdata,
  output logic                   tgt_wide,
  output logic                   tgt_burst,
  output bizt_pkg::bizt_phase_t  tgt_phase,
  input  wire logic [15:0]       tgt_rdata
);

  // Reset synchroniser
  logic rst_meta_ff;
  logic rst_sync_ff;
  logic rst_n;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  assign rst_n = rst_sync_ff;

  // Pin synchronisers, three stages; the first stage feeds only the second
  logic [2:0] pin_s1_ff;
  logic [2:0] pin_s2_ff;
  logic [2:0] pin_s3_ff;
  logic [1:0] sample_cnt_ff;
  logic       env_valid_ff;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_ff <= 3'h0;
      pin_s2_ff <= 3'h0;
      pin_s3_ff <= 3'h0;
    end else begin
      pin_s1_ff <= {flash_blank, boot_select_pins[1:0]};
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end

  // Third pin of the boot code rides a separate chain
  logic env2_s1_ff;
  logic env2_s2_ff;
  logic env2_s3_ff;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      env2_s1_ff <= 1'b0;
      env2_s2_ff <= 1'b0;
      env2_s3_ff <= 1'b0;
    end else begin
      env2_s1_ff <= boot_select_pins[2];
      env2_s2_ff <= env2_s1_ff;
      env2_s3_ff <= env2_s2_ff;
    end
  end

  // Environment decode
  function automatic bizt_pkg::bizt_env_t decode_env(input logic [2:0] code, input logic blank);
    bizt_pkg::bizt_env_t e;
    e = bizt_pkg::ENV_ISP;
    case (code)
      bizt_pkg::BOOT_INTERNAL: e = blank ? bizt_pkg::ENV_ISP : bizt_pkg::ENV_INTERNAL;
      bizt_pkg::BOOT_EXTERNAL: e = blank ? bizt_pkg::ENV_ISP : bizt_pkg::ENV_EXTERNAL;
      bizt_pkg::BOOT_EMU_EXT:  e = bizt_pkg::ENV_EMU_EXT;
      bizt_pkg::BOOT_EMU_INT:  e = bizt_pkg::ENV_EMU_INT;
      bizt_pkg::BOOT_ISP:      e = bizt_pkg::ENV_ISP;
      default:                 e = bizt_pkg::ENV_ISP;
    endcase
    return e;
  endfunction : decode_env

  // Latch environment once the sampled levels have settled after reset release
  logic [2:0] env_code;
  logic       env_stable;
  assign env_code   = {env2_s3_ff, pin_s3_ff[1:0]};
  assign env_stable = (env2_s2_ff == env2_s3_ff) && (pin_s2_ff == pin_s3_ff);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sample_cnt_ff <= 2'h0;
      env_valid_ff  <= 1'b0;
      env_mode      <= bizt_pkg::ENV_ISP;
    end else if (!env_valid_ff) begin
      if (sample_cnt_ff != bizt_pkg::ENV_SETTLE_CNT) begin
        sample_cnt_ff <= sample_cnt_ff + 2'h1;
      end else if (env_stable) begin
        env_mode     <= decode_env(env_code, pin_s3_ff[2]);
        env_valid_ff <= 1'b1;
      end
    end
  end

  // One-hot environment flags
  assign internal_program_mode      = (env_mode == bizt_pkg::ENV_INTERNAL);
  assign external_program_mode      = (env_mode == bizt_pkg::ENV_EXTERNAL);
  assign emulation_external_mode    = (env_mode == bizt_pkg::ENV_EMU_EXT);
  assign emulation_internal_mode    = (env_mode == bizt_pkg::ENV_EMU_INT);
  assign in_system_programming_mode = (env_mode == bizt_pkg::ENV_ISP);

  // Configuration registers
  logic [7:0]  write_timing_config_ff;
  logic [15:0] io_zone_config_ff;
  logic [15:0] static_zone0_config_ff;
  logic [15:0] static_zone1_config_ff;
  logic [15:0] static_zone2_config_ff;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      write_timing_config_ff <= bizt_pkg::RST_WRITE_TIMING;
      io_zone_config_ff      <= bizt_pkg::RST_ZONE_CFG;
      static_zone0_config_ff <= bizt_pkg::RST_ZONE_CFG;
      static_zone1_config_ff <= bizt_pkg::RST_ZONE12_CFG;
      static_zone2_config_ff <= bizt_pkg::RST_ZONE12_CFG;
    end else if (reg_write) begin
      case (reg_addr)
        // Bits 1 and 2 forced set so a careless write cannot clear them
        bizt_pkg::ADDR_WRITE_TIMING:
          write_timing_config_ff <= reg_wdata[7:0] | bizt_pkg::WT_FIXED_ONES;
        bizt_pkg::ADDR_IO_ZONE: io_zone_config_ff <= reg_wdata & bizt_pkg::IO_ZONE_MASK;
        bizt_pkg::ADDR_ZONE0:   static_zone0_config_ff <= reg_wdata & bizt_pkg::ZONE0_MASK;
        bizt_pkg::ADDR_ZONE1:   static_zone1_config_ff <= reg_wdata;
        bizt_pkg::ADDR_ZONE2:   static_zone2_config_ff <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Read data, one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_read) begin
      case (reg_addr)
        bizt_pkg::ADDR_WRITE_TIMING: reg_rdata <= {8'h00, write_timing_config_ff};
        bizt_pkg::ADDR_IO_ZONE:      reg_rdata <= io_zone_config_ff;
        bizt_pkg::ADDR_ZONE0:        reg_rdata <= static_zone0_config_ff;
        bizt_pkg::ADDR_ZONE1:        reg_rdata <= static_zone1_config_ff;
        bizt_pkg::ADDR_ZONE2:        reg_rdata <= static_zone2_config_ff;
        default:                     reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // Zone decode
  function automatic bizt_pkg::bizt_zone_t zone_of(input logic [23:0] a);
    bizt_pkg::bizt_zone_t z;
    z = bizt_pkg::ZONE_NONE;
    if (a >= bizt_pkg::IO_ZONE_BASE && a <= bizt_pkg::IO_ZONE_LAST) begin
      z = bizt_pkg::ZONE_IO;
    end else if (a <= bizt_pkg::ZONE0_LAST) begin
      z = bizt_pkg::ZONE_0;
    end
    return z;
  endfunction : zone_of

  // Resolve timing plan from the addressed zone and the write-timing early bit
  function automatic bizt_pkg::bizt_plan_t plan_of(input bizt_pkg::bizt_req_t r, input logic [15:0] cfg,
                                                   input logic is_zone0, input logic early);
    bizt_pkg::bizt_plan_t p;
    logic fast;
    p    = '0;
    fast = is_zone0 && cfg[bizt_pkg::FRE_BIT] && !r.write;
    p.zone       = zone_of(r.addr);
    p.fast       = fast;
    p.waits      = fast ? 3'h0 : cfg[bizt_pkg::WAIT_LSB +: 3];
    p.holds      = fast ? 2'h0 : cfg[bizt_pkg::HOLD_LSB +: 2];
    // I/O zone has no burst bits; only zone 0 honours them
    p.burst      = is_zone0 && !fast && !r.write && r.word && cfg[bizt_pkg::RBE_BIT]
                   && !cfg[bizt_pkg::BW_BIT];
    p.burst_wait = p.burst && cfg[bizt_pkg::WBR_BIT];
    p.early      = r.write && early;
    p.post_idle  = cfg[bizt_pkg::IDLE_AFTER_ZONE_CHANGE_BIT];
    return p;
  endfunction : plan_of

  // Request decode
  bizt_pkg::bizt_zone_t req_zone;
  logic [15:0]          req_cfg;
  bizt_pkg::bizt_plan_t req_plan;
  logic                 zone_change;
  logic                 need_pre;

  bizt_pkg::bizt_phase_t phase_ff;
  bizt_pkg::bizt_plan_t  plan_ff;
  bizt_pkg::bizt_req_t   req_ff;
  bizt_pkg::bizt_zone_t  last_zone_ff;
  logic                  post_pend_ff;
  logic [2:0]            cnt_ff;

  assign req_zone    = zone_of(core_req.addr);
  assign req_cfg     = (req_zone == bizt_pkg::ZONE_IO) ? io_zone_config_ff : static_zone0_config_ff;
  assign req_plan    = plan_of(core_req, req_cfg, req_zone == bizt_pkg::ZONE_0,
                               write_timing_config_ff[bizt_pkg::EWR_BIT]);
  assign zone_change = (req_zone != last_zone_ff);
  // Pre-idle is a zone 0 setting, so I/O cycles never take it
  assign need_pre    = zone_change && (req_zone == bizt_pkg::ZONE_0)
                       && static_zone0_config_ff[bizt_pkg::IDLE_BEFORE_ZONE_CHANGE_BIT];

  // Accept whenever idle, even when a post-idle cycle is owed
  assign core_ready = (phase_ff == bizt_pkg::PH_IDLE);

  // Cycle sequencer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase_ff     <= bizt_pkg::PH_IDLE;
      plan_ff      <= '0;
      req_ff       <= '0;
      last_zone_ff <= bizt_pkg::ZONE_NONE;
      post_pend_ff <= 1'b0;
      cnt_ff       <= 3'h0;
    end else begin
      case (phase_ff)
        bizt_pkg::PH_IDLE: begin
          if (core_valid && req_zone != bizt_pkg::ZONE_NONE) begin
            req_ff       <= core_req;
            plan_ff      <= req_plan;
            last_zone_ff <= req_zone;
            if (post_pend_ff && zone_change) begin
              phase_ff <= bizt_pkg::PH_POST;
            end else if (need_pre) begin
              phase_ff <= bizt_pkg::PH_PRE;
            end else if (req_plan.fast) begin
              phase_ff <= bizt_pkg::PH_DATA;
            end else begin
              phase_ff <= bizt_pkg::PH_ADDR;
            end
          end
        end
        bizt_pkg::PH_POST: begin
          post_pend_ff <= 1'b0;
          phase_ff     <= (plan_ff.zone == bizt_pkg::ZONE_0 && static_zone0_config_ff[bizt_pkg::IDLE_BEFORE_ZONE_CHANGE_BIT])
                          ? bizt_pkg::PH_PRE : (plan_ff.fast ? bizt_pkg::PH_DATA : bizt_pkg::PH_ADDR);
        end
        bizt_pkg::PH_PRE: begin
          phase_ff <= plan_ff.fast ? bizt_pkg::PH_DATA : bizt_pkg::PH_ADDR;
        end
        bizt_pkg::PH_ADDR: begin
          // Early write spends an extra cycle for address setup
          cnt_ff <= plan_ff.waits;
          if (plan_ff.early) begin
            plan_ff.early <= 1'b0;
            phase_ff      <= bizt_pkg::PH_ADDR;
          end else begin
            phase_ff <= (plan_ff.waits != 3'h0) ? bizt_pkg::PH_WAIT : bizt_pkg::PH_DATA;
          end
        end
        bizt_pkg::PH_WAIT: begin
          cnt_ff <= cnt_ff - 3'h1;
          if (cnt_ff == 3'h1) begin
            phase_ff <= bizt_pkg::PH_DATA;
          end
        end
        bizt_pkg::PH_DATA: begin
          cnt_ff <= {1'b0, plan_ff.holds};
          if (plan_ff.burst) begin
            plan_ff.burst <= 1'b0;
            phase_ff      <= plan_ff.burst_wait ? bizt_pkg::PH_BURST : bizt_pkg::PH_DATA;
          end else if (plan_ff.holds != 2'h0) begin
            phase_ff <= bizt_pkg::PH_HOLD;
          end else begin
            phase_ff     <= bizt_pkg::PH_IDLE;
            post_pend_ff <= plan_ff.post_idle;
          end
        end
        bizt_pkg::PH_BURST: begin
          plan_ff.burst_wait <= 1'b0;
          phase_ff           <= bizt_pkg::PH_DATA;
        end
        bizt_pkg::PH_HOLD: begin
          cnt_ff <= cnt_ff - 3'h1;
          if (cnt_ff == 3'h1) begin
            phase_ff     <= bizt_pkg::PH_IDLE;
            post_pend_ff <= plan_ff.post_idle;
          end
        end
        default: phase_ff <= bizt_pkg::PH_IDLE;
      endcase
    end
  end

  // Completion pulse and read capture at the last data beat
  logic last_beat;
  assign last_beat = (phase_ff == bizt_pkg::PH_DATA) && !plan_ff.burst;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      core_done  <= 1'b0;
      core_rdata <= 16'h0000;
    end else begin
      core_done <= last_beat;
      if (last_beat && !req_ff.write) begin
        core_rdata <= tgt_rdata;
      end
    end
  end

  // Target bus drive
  logic active;
  assign active           = (phase_ff != bizt_pkg::PH_IDLE) && (phase_ff != bizt_pkg::PH_PRE)
                            && (phase_ff != bizt_pkg::PH_POST);
  assign tgt_phase        = phase_ff;
  assign tgt_select_zone0 = active && (plan_ff.zone == bizt_pkg::ZONE_0);
  assign tgt_select_io    = active && (plan_ff.zone == bizt_pkg::ZONE_IO);
  assign tgt_addr         = req_ff.addr;
  assign tgt_wdata        = req_ff.wdata;
  assign tgt_rd           = active && !req_ff.write && (phase_ff != bizt_pkg::PH_HOLD);
  assign tgt_wr           = (phase_ff == bizt_pkg::PH_DATA) && req_ff.write;
  assign tgt_wide         = req_ff.word;
  assign tgt_burst        = active && (phase_ff == bizt_pkg::PH_BURST);

endmodule : bizt_top

// file: tb/bizt_checker.sv
// Port assertions for the zone timing bridge
`timescale 1ns/10ps
module bizt_checker (
  // Clock and reset
  input wire logic                  clock,
  input wire logic                  arst_n,
  // Environment outputs
  input wire bizt_pkg::bizt_env_t   env_mode,
  input wire logic                  internal_program_mode,
  input wire logic                  in_system_programming_mode,
  // Core and target side
  input wire logic                  core_done,
  input wire logic                  tgt_select_io,
  input wire logic                  tgt_wr,
  input wire logic [23:0]           tgt_addr,
  input wire bizt_pkg::bizt_phase_t tgt_phase
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  AST_ENV_INT: assert property (internal_program_mode |=> internal_program_mode && $stable(env_mode))
    else $error("internal program mode left before reset");
  AST_ENV_ISP: assert property (in_system_programming_mode == (env_mode == bizt_pkg::ENV_ISP))
    else $error("isp flag disagrees with env");
  AST_DONE_DATA: assert property (core_done |-> $past(tgt_phase) == bizt_pkg::PH_DATA)
    else $error("done not after data beat");
  AST_WAIT_ADDR: assert property (tgt_phase == bizt_pkg::PH_WAIT |->
    $past(tgt_phase) inside {bizt_pkg::PH_ADDR, bizt_pkg::PH_WAIT})
    else $error("wait cycle not after address");
  AST_WAIT_MAX: assert property ((tgt_phase == bizt_pkg::PH_WAIT) [*7] |=> tgt_phase != bizt_pkg::PH_WAIT)
    else $error("more than seven waits");
  AST_HOLD_END: assert property (tgt_phase == bizt_pkg::PH_HOLD && $past(tgt_phase) != bizt_pkg::PH_HOLD |->
    $past(tgt_phase) == bizt_pkg::PH_DATA)
    else $error("hold not after data");
  AST_HOLD_MAX: assert property ((tgt_phase == bizt_pkg::PH_HOLD) [*3] |=> tgt_phase != bizt_pkg::PH_HOLD)
    else $error("more than three holds");
  AST_BURST_BEAT: assert property (tgt_phase == bizt_pkg::PH_BURST |->
    $past(tgt_phase) == bizt_pkg::PH_DATA ##1 tgt_phase == bizt_pkg::PH_DATA)
    else $error("burst wait not between beats");
  AST_WR_DATA: assert property (tgt_wr |-> tgt_phase == bizt_pkg::PH_DATA)
    else $error("write strobe outside data");
  AST_IO_WINDOW: assert property (tgt_select_io && tgt_phase inside {bizt_pkg::PH_ADDR, bizt_pkg::PH_DATA} |->
    tgt_addr >= bizt_pkg::IO_ZONE_BASE && tgt_addr <= bizt_pkg::IO_ZONE_LAST)
    else $error("io select outside window");
  AST_POST_NEXT: assert property (tgt_phase == bizt_pkg::PH_POST |=>
    tgt_phase inside {bizt_pkg::PH_PRE, bizt_pkg::PH_ADDR, bizt_pkg::PH_DATA})
    else $error("post idle not followed by access");
endmodule : bizt_checker

bind bizt_top bizt_checker u_chk (.clock, .arst_n, .env_mode, .internal_program_mode,
  .in_system_programming_mode, .core_done, .tgt_select_io, .tgt_wr, .tgt_addr, .tgt_phase);

// file: tb/bizt_target_model.sv
// Target memory model: read data follows address, bus scrambles when not read
`timescale 1ns/10ps
module bizt_target_model (
  // Clock
  input  wire logic        clock,
  // Target bus
  input  wire logic        tgt_rd,
  input  wire logic [23:0] tgt_addr,
  output logic      [15:0] tgt_rdata
);
  logic [15:0] noise_ff = 16'h5A5A;
  // Released bus changes every cycle so stale data never passes
  always_ff @(posedge clock) begin
    noise_ff <= noise_ff + 16'h3B5D;
  end
  // Predictable data only while the read strobe stands
  assign tgt_rdata = tgt_rd ? {tgt_addr[7:0], ~tgt_addr[7:0]} : noise_ff;
endmodule : bizt_target_model

// file: tb/tb.sv
// Self-checking bench for the zone timing bridge
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb;
  logic clock = 1'b0, arst_n = 1'b0, flash_blank = 1'b0, reg_write = 1'b0, reg_read = 1'b0, core_valid = 1'b0;
  logic [2:0] boot_select_pins = 3'h7;
  logic [23:0] reg_addr = 24'h000000, tgt_addr;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, core_rdata, tgt_rdata, tgt_wdata, io_s, z0_s;
  logic internal_program_mode, external_program_mode, emulation_external_mode, emulation_internal_mode;
  logic in_system_programming_mode, core_ready, core_done, tgt_select_zone0, tgt_select_io;
  logic tgt_rd, tgt_wr, tgt_wide, tgt_burst, ew_s, prev_idle_after_zone_change;
  bizt_pkg::bizt_env_t env_mode;
  bizt_pkg::bizt_phase_t tgt_phase;
  bizt_pkg::bizt_zone_t prev_z;
  bizt_pkg::bizt_req_t core_req = '0;
  logic [4:0] flags;
  int miscompares = 0, n_compared = 0;
  logic [2:0] codes [5] = '{3'h7, 3'h3, 3'h0, 3'h1, 3'h6};

  bizt_top dut (.*);
  bizt_target_model u_tgt (.*);

  // Mode flags in environment code order, lowest code at bit 0
  assign flags = {in_system_programming_mode, emulation_internal_mode, emulation_external_mode,
                  external_program_mode, internal_program_mode};

  // Free-running 250 MHz clock
  always #2 clock = ~clock;

  task automatic end_sim();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim

  // Reset also restores the shadow of the timing registers
  task automatic do_reset();
    arst_n <= 1'b0;
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    repeat (12) @(posedge clock);
    ew_s = 1'b1;
    io_s = 16'h069F;
    z0_s = 16'h069F;
    prev_z = bizt_pkg::ZONE_NONE;
    prev_idle_after_zone_change = 1'b0;
  endtask : do_reset

  task automatic wr(input logic [23:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    @(posedge clock);
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [23:0] a, input logic [15:0] e);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 `CHK("reg_rdata", e, reg_rdata)
    @(posedge clock);
  endtask : rd

  // Software keeps bits 1,2 set and zone 0 wide
  task automatic cfg(input logic e, input logic [15:0] io, input logic [15:0] z0);
    wr(bizt_pkg::ADDR_WRITE_TIMING, 16'h0006 | {15'h0000, e});
    wr(bizt_pkg::ADDR_IO_ZONE, io);
    wr(bizt_pkg::ADDR_ZONE0, z0 | 16'h0080);
    ew_s = e;
    io_s = io & bizt_pkg::IO_ZONE_MASK;
    z0_s = (z0 | 16'h0080) & bizt_pkg::ZONE0_MASK;
  endtask : cfg

  // One core access; latency to done and holds to ready predicted from shadows
  task automatic acc(input logic [23:0] a, input logic w, input logic word);
    logic [15:0] c, d;
    logic z0, bst, chg;
    bizt_pkg::bizt_zone_t cz;
    int k, h, n, pp, nw = 0, nb = 0, ns = 0, nx = 0;
    z0 = a <= bizt_pkg::ZONE0_LAST;
    c = z0 ? z0_s : io_s;
    cz = z0 ? bizt_pkg::ZONE_0 : bizt_pkg::ZONE_IO;
    // No zone before the first access after reset also counts as a change
    chg = prev_z != cz;
    bst = z0 && !w && word && !c[7] && c[5];
    k = 3 + c[2:0] + (w && ew_s) + bst + (bst && c[6]);
    h = int'(c[4:3]);
    if (z0 && !w && c[11]) begin
      k = 2;
      h = 0;
      bst = 1'b0;
    end
    pp = (chg && prev_idle_after_zone_change) + (chg && z0 && c[10]);
    k = k + pp;
    d = 16'($urandom);
    core_req <= '{addr: a, write: w, word: word, wdata: d};
    core_valid <= 1'b1;
    @(posedge clock);
    core_valid <= 1'b0;
    // Count from the sampling edge; every cycle up to the last beat is looked at
    n = 1;
    #1;
    do begin
      nw += tgt_wr;
      nb += tgt_burst;
      ns += z0 ? tgt_select_zone0 : tgt_select_io;
      nx += z0 ? tgt_select_io : tgt_select_zone0;
      @(posedge clock);
      n++;
      #1;
    end while (n < 40 && core_done !== 1'b1);
    `CHK("latency", k, n)
    `CHK("tgt_wr", w ? 1 : 0, nw)
    `CHK("tgt_burst", (bst && c[6]) ? 1 : 0, nb)
    `CHK("tgt_select", k - 1 - pp, ns)
    `CHK("tgt_select_other", 0, nx)
    `CHK("tgt_req", {a, word, d}, {tgt_addr, tgt_wide, tgt_wdata})
    if (!w) `CHK("core_rdata", {a[7:0], ~a[7:0]}, core_rdata)
    n = 0;
    while (n < 20 && core_ready !== 1'b1) begin
      @(posedge clock);
      n++;
      #1;
    end
    `CHK("holds", h, n)
    prev_z = cz;
    prev_idle_after_zone_change = c[9];
    // Leave on a rising edge so the next request is driven there
    @(posedge clock);
  endtask : acc

  function automatic bizt_pkg::bizt_env_t exp_env(input logic [2:0] p, input logic b);
    case (p)
      3'h7: exp_env = b ? bizt_pkg::ENV_ISP : bizt_pkg::ENV_INTERNAL;
      3'h3: exp_env = b ? bizt_pkg::ENV_ISP : bizt_pkg::ENV_EXTERNAL;
      3'h0: exp_env = bizt_pkg::ENV_EMU_EXT;
      3'h1: exp_env = bizt_pkg::ENV_EMU_INT;
      default: exp_env = bizt_pkg::ENV_ISP;
    endcase
  endfunction : exp_env

  // Watchdog sized well above the expected run
  initial begin
    #200000;
    miscompares++;
    end_sim();
  end

  // Main sequence
  initial begin
    void'($urandom(32'h39A6A1D4));
    foreach (codes[i]) begin
      for (int b = 0; b < 2; b++) begin
        boot_select_pins <= codes[i];
        flash_blank <= b[0];
        do_reset();
        `CHK("env_mode", exp_env(codes[i], b[0]), env_mode)
        `CHK("env_flags", 5'(5'h01 << exp_env(codes[i], b[0])), flags)
      end
    end
    $display("test env done");
    rd(bizt_pkg::ADDR_WRITE_TIMING, 16'h0007);
    rd(bizt_pkg::ADDR_IO_ZONE, 16'h069F);
    rd(bizt_pkg::ADDR_ZONE0, 16'h069F);
    rd(24'hFFF90A, 16'h0000);
    acc(24'h000100, 1'b0, 1'b1);
    acc(24'h000102, 1'b1, 1'b1);
    wr(bizt_pkg::ADDR_WRITE_TIMING, 16'h0006);
    ew_s = 1'b0;
    rd(bizt_pkg::ADDR_WRITE_TIMING, 16'h0006);
    acc(24'h000104, 1'b1, 1'b1);
    $display("test reset config done");
    cfg(1'b0, 16'h0080, 16'h089F);
    acc(24'h000200, 1'b0, 1'b1);
    acc(bizt_pkg::IO_ZONE_BASE, 1'b0, 1'b1);
    acc(bizt_pkg::IO_ZONE_LAST, 1'b1, 1'b0);
    acc(bizt_pkg::ZONE0_LAST, 1'b0, 1'b0);
    wr(bizt_pkg::ADDR_ZONE0, 16'h0060);
    z0_s = 16'h0060;
    acc(24'h000300, 1'b0, 1'b1);
    acc(24'h000301, 1'b0, 1'b0);
    z0_s = 16'h0020;
    wr(bizt_pkg::ADDR_ZONE0, 16'h0020);
    acc(24'h000302, 1'b0, 1'b1);
    cfg(1'b0, 16'h0280, 16'h0480);
    acc(24'hFFFB10, 1'b0, 1'b1);
    acc(24'h000400, 1'b0, 1'b1);
    acc(24'h000402, 1'b1, 1'b1);
    acc(24'hFFFB12, 1'b1, 1'b1);
    $display("test corners done");
    for (int i = 0; i < 40; i++) begin
      cfg(1'($urandom), 16'($urandom) & 16'hFDFF, 16'($urandom) & 16'hF9FF);
      repeat (4) begin
        if ($urandom % 2) acc(24'($urandom % 32'h000E0000), 1'($urandom), 1'($urandom));
        else acc({16'hFFFB, 8'($urandom)}, 1'($urandom), 1'($urandom));
      end
    end
    $display("test random done");
    core_req <= '{addr: 24'hFFFC00, write: 1'b0, word: 1'b1, wdata: 16'h0000};
    core_valid <= 1'b1;
    @(posedge clock);
    core_valid <= 1'b0;
    repeat (12) begin
      @(posedge clock);
      #1 `CHK("core_done", 1'b0, core_done)
    end
    $display("test unmapped done");
    end_sim();
  end
endmodule : tb
